// ---- hw/cet_cfg.svh ----
// Purpose: Constants of the execution state timing block
// Assumes: One CPU clock, figures counted in states
// Notes:   Included by its bare name; definitions only
`ifndef CET_CFG_SVH
`define CET_CFG_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define CET_CLK_PERIOD_NS   100

// ----------------------------------------------------------------------
// States per cycle, on-chip memory and internal operation
// ----------------------------------------------------------------------
`define CET_MEM_FETCH_ST    2'h2
`define CET_MEM_BRANCH_ST   2'h2
`define CET_MEM_STACK_ST    2'h2
`define CET_MEM_BYTE_ST     2'h2
`define CET_MEM_WORD_ST     2'h2
`define CET_INTERNAL_ST     2'h1

// ----------------------------------------------------------------------
// States per byte cycle, on-chip peripheral module
// ----------------------------------------------------------------------
`define CET_PERI_FAST_ST    2'h2
`define CET_PERI_SLOW_ST    2'h3

// ----------------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------------
`define CET_CNT_W           2
`define CET_TOTAL_W         6

`endif

// ---- hw/cet_pkg.sv ----
// Purpose: Types of the execution state timing block
// Assumes: Form codes are driven by the instruction decoder
// Notes:   Codes not listed here count as zero cycles
package cet_pkg;

    // ------------------------------------------------------------------
    // Instruction forms covered by the timing table
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        FORM_ADD_B_IMM,
        FORM_ADD_B_REG,
        FORM_ADD_W_IMM,
        FORM_ADD_W_REG,
        FORM_ADD_L_IMM,
        FORM_ADD_L_REG,
        FORM_ADD_SMALL_CONSTANT,
        FORM_ADD_WITH_CARRY_IMM,
        FORM_ADD_WITH_CARRY_REG,
        FORM_AND_B_IMM,
        FORM_AND_B_REG,
        FORM_AND_W_IMM,
        FORM_AND_W_REG,
        FORM_AND_L_IMM,
        FORM_AND_L_REG,
        FORM_AND_INTO_FLAGS,
        FORM_BIT_AND_REG,
        FORM_BIT_AND_INDIRECT,
        FORM_BIT_AND_ABS8,
        FORM_BRANCH_D8
    } cet_form_e;

endpackage

// ---- hw/cet_term.sv ----
// Purpose: One weighted term, cycle count times states per cycle
// Assumes: Inputs stable within the cycle
// Notes:   Purely combinational, six copies in the timing block
`timescale 1ns/1ps

module cet_term #(
    parameter int CNT_W  = 2,
    parameter int COST_W = 2
) (
    input  wire logic [CNT_W-1:0]        count,
    input  wire logic [COST_W-1:0]       cost,
    output logic [CNT_W+COST_W-1:0]      product
);

    // ------------------------------------------------------------------
    // Product at full width, so no bits are lost
    // ------------------------------------------------------------------
    always_comb
    begin
        product = {{COST_W{1'b0}}, count} * {{CNT_W{1'b0}}, cost};
    end

endmodule

// ---- hw/cet_timing.sv ----
// Purpose: States taken by each instruction, and a busy window that long
// Assumes: Form code and access location come from same-clock logic
// Notes:   One instruction at a time; start is ignored while busy
// What this block does
// [RQ1] Total is sum of count times cost
// [RQ2] Memory fetch and byte access: 2 states
// [RQ3] Memory branch read and stack: 2 states
// [RQ4] Peripheral byte access: 2 or 3 states
// [RQ5] Simple register and 8-bit forms: one fetch
// [RQ6] Word immediate add or AND: two fetches
// [RQ7] Long immediate add or AND: three fetches
// [RQ8] Long register AND two fetches, add one
// [RQ9] Bit-AND register one fetch, memory 2+1
// [RQ10] 8-bit branches: two fetches, no internal
// [RQ11] Unlisted cycle types count as zero
`timescale 1ns/1ps
`include "cet_cfg.svh"

module cet_timing (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    start,
    input  wire logic [4:0]              form_code,
    input  wire logic                    byte_periph,
    input  wire logic                    periph_slow,
    output logic                         busy,
    output logic                         done,
    output logic [`CET_CNT_W-1:0]        fetch_cycles,
    output logic [`CET_CNT_W-1:0]        branch_read_cycles,
    output logic [`CET_CNT_W-1:0]        stack_cycles,
    output logic [`CET_CNT_W-1:0]        byte_cycles,
    output logic [`CET_CNT_W-1:0]        word_cycles,
    output logic [`CET_CNT_W-1:0]        internal_cycles,
    output logic [`CET_TOTAL_W-1:0]      total_states
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [`CET_CNT_W-1:0]   cnt_d [6];      // Decoded counts, I..N
    logic [1:0]              cost  [6];      // States per cycle, I..N
    logic [3:0]              term  [6];      // Weighted terms
    logic [`CET_TOTAL_W-1:0] total_d;        // Sum of the terms
    logic [`CET_CNT_W-1:0]   cnt_q [6];      // Latched counts
    logic [`CET_TOTAL_W-1:0] total_q;        // Latched total
    logic [`CET_TOTAL_W-1:0] rem_q;          // States still to run
    logic                    done_q;         // End-of-instruction pulse
    logic                    accept;         // Start taken this edge

    assign busy   = (rem_q != '0);
    assign accept = start && !busy;

    // ------------------------------------------------------------------
    // Cycle counts per form; anything unlisted stays zero
    // ------------------------------------------------------------------
    always_comb
    begin
        cnt_d = '{default: '0};                              // RQ11
        case (form_code)
            cet_pkg::FORM_ADD_W_IMM,
            cet_pkg::FORM_AND_W_IMM:
            begin
                cnt_d[0] = 2'h2;                             // RQ6
            end
            cet_pkg::FORM_ADD_L_IMM,
            cet_pkg::FORM_AND_L_IMM:
            begin
                cnt_d[0] = 2'h3;                             // RQ7
            end
            cet_pkg::FORM_AND_L_REG:
            begin
                // Long AND needs an extra prefix word
                cnt_d[0] = 2'h2;                             // RQ8
            end
            cet_pkg::FORM_BIT_AND_INDIRECT,
            cet_pkg::FORM_BIT_AND_ABS8:
            begin
                cnt_d[0] = 2'h2;                             // RQ9
                cnt_d[3] = 2'h1;                             // RQ9
            end
            cet_pkg::FORM_BRANCH_D8:
            begin
                // Taken or not, same cost
                cnt_d[0] = 2'h2;                             // RQ10
            end
            cet_pkg::FORM_ADD_B_IMM,
            cet_pkg::FORM_ADD_B_REG,
            cet_pkg::FORM_ADD_W_REG,
            cet_pkg::FORM_ADD_L_REG,
            cet_pkg::FORM_ADD_SMALL_CONSTANT,
            cet_pkg::FORM_ADD_WITH_CARRY_IMM,
            cet_pkg::FORM_ADD_WITH_CARRY_REG,
            cet_pkg::FORM_AND_B_IMM,
            cet_pkg::FORM_AND_B_REG,
            cet_pkg::FORM_AND_W_REG,
            cet_pkg::FORM_AND_INTO_FLAGS,
            cet_pkg::FORM_BIT_AND_REG:
            begin
                cnt_d[0] = 2'h1;                             // RQ5
            end
            default:
            begin
                // Unknown code: zero cycles of every type
                cnt_d[0] = '0;                               // RQ11
            end
        endcase
    end

    // ------------------------------------------------------------------
    // States per cycle by type and access location
    // ------------------------------------------------------------------
    always_comb
    begin
        cost[0] = `CET_MEM_FETCH_ST;                         // RQ2
        cost[1] = `CET_MEM_BRANCH_ST;                        // RQ3
        cost[2] = `CET_MEM_STACK_ST;                         // RQ3
        cost[4] = `CET_MEM_WORD_ST;
        cost[5] = `CET_INTERNAL_ST;
        // Peripheral speed depends on the module addressed
        if (byte_periph)
        begin
            cost[3] = periph_slow ? `CET_PERI_SLOW_ST
                                  : `CET_PERI_FAST_ST;       // RQ4
        end
        else
        begin
            cost[3] = `CET_MEM_BYTE_ST;                      // RQ2
        end
    end

    // ------------------------------------------------------------------
    // Weighted terms, one multiplier per cycle type
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 6; g++)
    begin : g_term
        cet_term #(
            .CNT_W  (`CET_CNT_W),
            .COST_W (2)
        ) u_term (
            .count   (cnt_d[g]),
            .cost    (cost[g]),
            .product (term[g])
        );
    end

    // ------------------------------------------------------------------
    // Sum of the six terms
    // ------------------------------------------------------------------
    always_comb
    begin
        total_d = '0;
        for (int i = 0; i < 6; i++)
        begin
            total_d = total_d + {2'h0, term[i]};             // RQ1
        end
    end

    // ------------------------------------------------------------------
    // Latched counts and total, held until the next start
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q   <= '{default: '0};
            total_q <= '0;
        end
        else if (accept)
        begin
            cnt_q   <= cnt_d;
            total_q <= total_d;                              // RQ1
        end
    end

    // ------------------------------------------------------------------
    // State countdown; busy lasts exactly the total
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rem_q <= '0;
        end
        else if (accept)
        begin
            rem_q <= total_d;                                // RQ1
        end
        else if (busy)
        begin
            rem_q <= rem_q - 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Done pulse after the last state; zero total ends at once
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= (accept && total_d == '0) ||
                      (!accept && rem_q == 6'h01);
        end
    end

    assign done               = done_q;
    assign fetch_cycles       = cnt_q[0];
    assign branch_read_cycles = cnt_q[1];
    assign stack_cycles       = cnt_q[2];
    assign byte_cycles        = cnt_q[3];
    assign word_cycles        = cnt_q[4];
    assign internal_cycles    = cnt_q[5];
    assign total_states       = total_q;

    // ------------------------------------------------------------------
    // Checks; the busy counter is helper logic only
    // ------------------------------------------------------------------
    logic [`CET_TOTAL_W-1:0] run_cnt_q;      // Busy cycles seen

    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            run_cnt_q <= '0;
        end
        else if (accept)
        begin
            run_cnt_q <= '0;
        end
        else if (busy)
        begin
            run_cnt_q <= run_cnt_q + 6'h01;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    chk_busy_length: assert property ( // RQ1
        done |-> run_cnt_q == total_q)
        else $error("busy window differs from state total");
    chk_mem_byte: assert property ( // RQ2
        accept && form_code == cet_pkg::FORM_BIT_AND_INDIRECT
        && !byte_periph |=> total_states == 6'h06)
        else $error("memory byte access not two states");
    chk_periph_slow: assert property ( // RQ4
        accept && form_code == cet_pkg::FORM_BIT_AND_ABS8
        && byte_periph && periph_slow |=> total_states == 6'h07)
        else $error("slow peripheral byte access not three states");
    chk_periph_fast: assert property ( // RQ4
        accept && form_code == cet_pkg::FORM_BIT_AND_ABS8
        && byte_periph && !periph_slow |=> total_states == 6'h06)
        else $error("fast peripheral byte access not two states");
    chk_one_fetch: assert property ( // RQ5
        accept && form_code == cet_pkg::FORM_AND_INTO_FLAGS
        |=> fetch_cycles == 2'h1 && total_states == 6'h02
        ##1 busy ##1 done)
        else $error("single fetch form mistimed");
    chk_word_imm: assert property ( // RQ6
        accept && form_code == cet_pkg::FORM_ADD_W_IMM
        |=> fetch_cycles == 2'h2 && byte_cycles == 2'h0
        && total_states == 6'h04)
        else $error("word immediate not two fetches");
    chk_long_imm: assert property ( // RQ7
        accept && form_code == cet_pkg::FORM_AND_L_IMM
        |=> busy [*6] ##1 done)
        else $error("long immediate not six states");
    chk_long_reg: assert property ( // RQ8
        accept && form_code == cet_pkg::FORM_AND_L_REG
        |=> fetch_cycles == 2'h2 && total_states == 6'h04)
        else $error("long register AND not two fetches");
    chk_bit_reg: assert property ( // RQ9
        accept && form_code == cet_pkg::FORM_BIT_AND_REG
        |=> fetch_cycles == 2'h1 && byte_cycles == 2'h0)
        else $error("bit-AND on register mistimed");
    chk_branch_d8: assert property ( // RQ10
        accept && form_code == cet_pkg::FORM_BRANCH_D8
        |=> fetch_cycles == 2'h2 && internal_cycles == 2'h0
        && total_states == 6'h04)
        else $error("short branch mistimed");
    chk_unknown_zero: assert property ( // RQ11
        accept && form_code > cet_pkg::FORM_BRANCH_D8
        |=> total_states == 6'h00 && done && !busy)
        else $error("unlisted form not zero states");
    cov_branch: cover property (
        accept && form_code == cet_pkg::FORM_BRANCH_D8);
    cov_slow_periph: cover property (
        accept && byte_periph && periph_slow && total_d == 6'h07);
    cov_back_to_back: cover property (done ##0 accept);

endmodule

// ---- testbench/cet_periph_map.sv ----
// Purpose: Far-side model, the location that a byte access reaches
// Assumes: Region code chosen by the bench for each instruction
// Notes:   Region 0 memory, 1 fast module, 2 and 3 slow modules
`timescale 1ns/1ps

module cet_periph_map (
    input  wire logic [1:0] region,
    output logic            byte_periph,
    output logic            periph_slow
);
    // ------------------------------------------------------------------
    // Location decode
    // ------------------------------------------------------------------
    // Any non-zero region is a peripheral module, zero is memory
    assign byte_periph = (region != 2'h0);
    // Upper half of the map holds the modules needing a third state
    assign periph_slow = region[1];
endmodule

// ---- testbench/cpu_execution_state_timing_bench.sv ----
// Purpose: Self-checking bench for the execution state timing block
// Assumes: Inputs change at the falling edge of a 100 ns clock
// Notes:   Expected counts come from tables held in the bench
`timescale 1ns/1ps
`include "cet_cfg.svh"

module cpu_execution_state_timing_bench;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                    sys_clk = 1'b0; // Bench clock
    logic                    sys_rst;        // Async reset
    logic                    start;          // Timing request
    logic [4:0]              form_code;      // Instruction form
    logic [1:0]              region;         // Access location code
    logic                    byte_periph;    // From location model
    logic                    periph_slow;    // From location model
    logic                    busy;
    logic                    done;
    logic [`CET_CNT_W-1:0]   fetch_cycles;
    logic [`CET_CNT_W-1:0]   branch_read_cycles;
    logic [`CET_CNT_W-1:0]   stack_cycles;
    logic [`CET_CNT_W-1:0]   byte_cycles;
    logic [`CET_CNT_W-1:0]   word_cycles;
    logic [`CET_CNT_W-1:0]   internal_cycles;
    logic [`CET_TOTAL_W-1:0] total_states;
    int                      error_cnt = 0;
    int                      check_count = 0;
    int                      cyc = 0;        // Hang guard
    // Fetch and byte cycles of each listed form, in code order
    int fetch_tab [20] = '{1,1,2,1,3,1,1,1,1,1,1,2,1,3,2,1,1,2,2,2};
    int byte_tab  [20] = '{0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,0,1,1,0};
    int                      exp_q [$];      // Model totals in flight

    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    cet_periph_map cet_periph_map_i (
        .region      (region),
        .byte_periph (byte_periph),
        .periph_slow (periph_slow)
    );

    cet_timing cet_timing_i (
        .sys_clk            (sys_clk),
        .sys_rst            (sys_rst),
        .start              (start),
        .form_code          (form_code),
        .byte_periph        (byte_periph),
        .periph_slow        (periph_slow),
        .busy               (busy),
        .done               (done),
        .fetch_cycles       (fetch_cycles),
        .branch_read_cycles (branch_read_cycles),
        .stack_cycles       (stack_cycles),
        .byte_cycles        (byte_cycles),
        .word_cycles        (word_cycles),
        .internal_cycles    (internal_cycles),
        .total_states       (total_states)
    );

    // ------------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------------
    // Half period toggling
    always #(`CET_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    // Whole run needs about 300 cycles, so 3000 means a hang
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            $display("mismatch at %0t: run too long", $time);
            give_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // One comparison, counted; mismatch reported at once
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, what,
                     got, exp);
        end
    endtask

    // Times one instruction; entered and left at a falling edge.
    // Leaves in the done cycle so the caller may chain back to back.
    // With intr set a second start is raised while busy, which the
    // block must ignore; needs a form of at least two states.
    task automatic run_one(input int f, input int r, input bit intr);
        int ef;
        int eb;
        int et;
        int n;
        ef = (f < 20) ? fetch_tab[f] : 0;
        eb = (f < 20) ? byte_tab[f] : 0;
        et = ef * 2 + eb * ((r >= 2) ? 3 : 2);
        exp_q.push_back(et);
        n = 0;
        start = 1'b1;
        form_code = 5'(f);
        region = 2'(r);
        @(negedge sys_clk);
        start = 1'b0;
        while (busy === 1'b1 && n < 40)
        begin
            n++;
            chk({15'h0000, done}, 16'h0000, "done while busy");
            if (intr && n == 1)
            begin
                start = 1'b1;
                form_code = 5'(cet_pkg::FORM_BIT_AND_ABS8);
                region = 2'h3;
            end
            else
                start = 1'b0;
            @(negedge sys_clk);
        end
        // Oldest expectation belongs to the instruction just ended
        et = exp_q.pop_front();
        chk(16'(n), 16'(et), "busy length");
        chk({15'h0000, done}, 16'h0001, "done pulse");
        chk({14'h0, fetch_cycles}, 16'(ef), "fetch");
        chk({14'h0, byte_cycles}, 16'(eb), "byte");
        chk({8'h00, branch_read_cycles, stack_cycles, word_cycles,
             internal_cycles}, 16'h0000, "zero kinds");
        chk({10'h000, total_states}, 16'(et), "total");
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        start = 1'b0;
        form_code = 5'h00;
        region = 2'h0;
        void'($urandom(32'h7C99));
        repeat (20) @(negedge sys_clk);
        chk({busy, done, total_states}, 16'h0000, "reset");
        sys_rst = 1'b0;
        @(negedge sys_clk);
        $display("test reset values done");

        // Every code, listed and unlisted, with a gap after each
        for (int f = 0; f < 32; f++)
        begin
            run_one(f, $urandom_range(3), 1'b0);
            @(negedge sys_clk);
            chk({15'h0000, done}, 16'h0000, "done width");
        end
        $display("test all forms done");

        // Bit-AND on memory operands in every location, chained
        for (int r = 0; r < 4; r++)
        begin
            run_one(17, r, 1'b0);
            run_one(18, r, 1'b0);
        end
        $display("test byte locations done");

        // Random forms back to back
        repeat (20)
            run_one($urandom_range(31), $urandom_range(3), 1'b0);
        $display("test back to back done");

        // Start while busy is ignored
        run_one(13, 0, 1'b1);
        $display("test start while busy done");

        // Reset in mid instruction, then a branch
        start = 1'b1;
        form_code = 5'(cet_pkg::FORM_AND_L_IMM);
        @(negedge sys_clk);
        start = 1'b0;
        sys_rst = 1'b1;
        @(negedge sys_clk);
        chk({busy, done, total_states}, 16'h0000, "mid reset");
        sys_rst = 1'b0;
        @(negedge sys_clk);
        run_one(19, 0, 1'b0);
        $display("test mid reset done");
        give_verdict();
    end
endmodule
